/* File: core/cs_hold_pkg.sv */
// shared constants for the chip-select and bus-hold block
package cs_hold_pkg;
    localparam int NUM_CS = 6;
    localparam int ADDR_W = 20;
    localparam int BOOT_CS = 0;
    // base compare and size mask compare address bits 19:8
    localparam int CMP_LSB = 8;
    localparam int CMP_W = 12;
    // bus configuration byte fields
    localparam int CFG_DEMUX_BIT = 7;
    localparam int CFG_WIDTH16_BIT = 6;
    localparam int CFG_WAIT_LSB = 0;
    localparam int CFG_WAIT_W = 4;
    // boot region: whole space, demultiplexed 16-bit, zero waits
    localparam logic [CMP_W-1:0] BOOT_BASE_RST = 12'h000;
    localparam logic [CMP_W-1:0] BOOT_MASK_RST = 12'h000;
    localparam logic [CMP_W-1:0] BASE_RST = 12'hFFF;
    localparam logic [CMP_W-1:0] MASK_RST = 12'hFFF;
    localparam logic [7:0] BOOT_CFG_RST = 8'hC0;
    localparam logic [7:0] CFG_RST = 8'hC0;
    // port 2 pin positions used by the hold protocol
    localparam int P2_REQ_OUT_BIT = 3;
    localparam int P2_TAKEOVER_BIT = 5;
    localparam int P2_GRANT_BIT = 6;
    typedef enum logic [3:0] {
        HOLD_IDLE = 4'b0001,
        HOLD_DRAIN = 4'b0010,
        HOLD_GRANTED = 4'b0100,
        HOLD_RESUME = 4'b1000
    } hold_state_t;
endpackage

/* File: core/region_decode.sv */
// one chip-select region: compare, mask, bus characteristics
`timescale 1ns/1ps
module region_decode (
    input wire logic [cs_hold_pkg::ADDR_W-1:0] addr,
    input wire logic [cs_hold_pkg::CMP_W-1:0] base_compare,
    input wire logic [cs_hold_pkg::CMP_W-1:0] size_mask,
    input wire logic [7:0] bus_config,
    output logic hit,
    output logic demux,
    output logic width16,
    output logic [cs_hold_pkg::CFG_WAIT_W-1:0] wait_states
);
    logic [cs_hold_pkg::CMP_W-1:0] addr_hi;
    always_comb begin
        addr_hi = addr[cs_hold_pkg::ADDR_W-1:cs_hold_pkg::CMP_LSB];
        // masked bits set region size, base sets region start
        hit = ((addr_hi ^ base_compare) & size_mask) == '0; // RULE_02 RULE_03
        demux = bus_config[cs_hold_pkg::CFG_DEMUX_BIT]; // RULE_04
        width16 = bus_config[cs_hold_pkg::CFG_WIDTH16_BIT]; // RULE_04
        wait_states = bus_config[cs_hold_pkg::CFG_WAIT_LSB +: cs_hold_pkg::CFG_WAIT_W]; // RULE_04
    end
endmodule

/* File: core/chip_select_and_bus_hold.sv */
// chip-select decoding, pin function muxing and bus-hold handshake
`timescale 1ns/1ps
// What this block does and what it relies on
// RULE_01: boot region select is active straight out of reset.
// RULE_02: each region start comes from its base compare value.
// RULE_03: each region size comes from its size mask value.
// RULE_04: bus config byte sets bus type, width, wait states; 0C0h demux 16-bit.
// RULE_05: software must not reprogram a region while executing from it.
// RULE_06: select pin can switch to general output low and back.
// RULE_07: bus request out asserted in hold while external cycle pending.
// RULE_08: protocol enable locks bus request pin, ignoring port settings.
// RULE_09: grant ack asserted once the bus has been released.
// RULE_10: protocol enable locks grant ack pin, ignoring port settings.
// RULE_11: external master drives takeover request low to want the bus.
// RULE_12: protocol enable locks takeover pin as input, ignoring port settings.
// RULE_13: grant held until request released; bus cycles resume afterwards.
module chip_select_and_bus_hold (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [cs_hold_pkg::ADDR_W-1:0] bus_addr,
    input wire logic bus_cycle_pending,
    input wire logic bus_cycle_active,
    input wire logic cfg_write,
    input wire logic [2:0] cfg_index,
    input wire logic [cs_hold_pkg::CMP_W-1:0] cfg_base,
    input wire logic [cs_hold_pkg::CMP_W-1:0] cfg_mask,
    input wire logic [7:0] cfg_bus,
    input wire logic [cs_hold_pkg::NUM_CS-1:0] port3_function_select,
    input wire logic [cs_hold_pkg::NUM_CS-1:0] port3_output_value,
    input wire logic takeover_protocol_enable,
    input wire logic [7:0] port2_function_select,
    input wire logic [7:0] port2_direction,
    input wire logic [7:0] port2_output_value,
    input wire logic takeover_req_n_in,
    input wire logic bus_request_out_in,
    input wire logic bus_grant_ack_in,
    output logic [cs_hold_pkg::NUM_CS-1:0] region_select_n,
    output logic boot_region_select,
    output logic sel_demux,
    output logic sel_width16,
    output logic [cs_hold_pkg::CFG_WAIT_W-1:0] sel_wait_states,
    output logic bus_released,
    output logic bus_request_out,
    output logic bus_request_oe_n,
    output logic bus_grant_ack,
    output logic bus_grant_oe_n,
    output logic takeover_oe_n,
    output logic takeover_req_seen,
    output logic [cs_hold_pkg::NUM_CS-1:0] region_hit
);
    localparam int N = cs_hold_pkg::NUM_CS;
    localparam int CW = cs_hold_pkg::CMP_W;

    logic [CW-1:0] base [N];
    logic [CW-1:0] mask [N];
    logic [7:0] bcfg [N];
    logic [CW-1:0] next_base [N];
    logic [CW-1:0] next_mask [N];
    logic [7:0] next_bcfg [N];
    logic [N-1:0] dmx;
    logic [N-1:0] w16;
    logic [cs_hold_pkg::CFG_WAIT_W-1:0] wst [N];
    logic [N-1:0] next_sel_n;
    logic next_demux;
    logic next_width16;
    logic [cs_hold_pkg::CFG_WAIT_W-1:0] next_wait;
    cs_hold_pkg::hold_state_t state;
    cs_hold_pkg::hold_state_t next_state;
    logic req_n;
    logic next_req_n;
    logic grant_n;
    logic next_grant_n;
    logic takeover;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : gen_region
            region_decode u_dec (
                .addr(bus_addr),
                .base_compare(base[g]),
                .size_mask(mask[g]),
                .bus_config(bcfg[g]),
                .hit(region_hit[g]),
                .demux(dmx[g]),
                .width16(w16[g]),
                .wait_states(wst[g])
            );
        end
    endgenerate

    // region configuration store
    always_comb begin
        for (int i = 0; i < N; i++) begin
            next_base[i] = base[i];
            next_mask[i] = mask[i];
            next_bcfg[i] = bcfg[i];
        end
        if (cfg_write && (int'(cfg_index) < N)) begin
            next_base[cfg_index] = cfg_base; // RULE_02
            next_mask[cfg_index] = cfg_mask; // RULE_03
            next_bcfg[cfg_index] = cfg_bus; // RULE_04
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < N; i++) begin
                base[i] <= (i == cs_hold_pkg::BOOT_CS) ?
                    cs_hold_pkg::BOOT_BASE_RST : cs_hold_pkg::BASE_RST;
                mask[i] <= (i == cs_hold_pkg::BOOT_CS) ?
                    cs_hold_pkg::BOOT_MASK_RST : cs_hold_pkg::MASK_RST;
                bcfg[i] <= (i == cs_hold_pkg::BOOT_CS) ?
                    cs_hold_pkg::BOOT_CFG_RST : cs_hold_pkg::CFG_RST;
            end
        end else if (clk_en) begin
            for (int i = 0; i < N; i++) begin
                base[i] <= next_base[i];
                mask[i] <= next_mask[i];
                bcfg[i] <= next_bcfg[i];
            end
        end
    end

    // select pins: in an active cycle with the bus not released, every hit region asserts its own pin and the lowest hit sets bus type; gpio mode overrides the select
    always_comb begin
        next_sel_n = '1;
        next_demux = cs_hold_pkg::BOOT_CFG_RST[cs_hold_pkg::CFG_DEMUX_BIT];
        next_width16 = cs_hold_pkg::BOOT_CFG_RST[cs_hold_pkg::CFG_WIDTH16_BIT];
        next_wait = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (region_hit[i] && bus_cycle_active && !bus_released) begin
                next_demux = dmx[i]; // RULE_04
                next_width16 = w16[i]; // RULE_04
                next_wait = wst[i]; // RULE_04
            end
        end
        for (int i = 0; i < N; i++) begin
            if (port3_function_select[i]) begin
                next_sel_n[i] = !(region_hit[i] && bus_cycle_active && !bus_released);
            end else begin
                next_sel_n[i] = port3_output_value[i]; // RULE_06
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            region_select_n <= '1;
            region_select_n[cs_hold_pkg::BOOT_CS] <= 1'b0; // RULE_01
            sel_demux <= cs_hold_pkg::BOOT_CFG_RST[cs_hold_pkg::CFG_DEMUX_BIT];
            sel_width16 <= cs_hold_pkg::BOOT_CFG_RST[cs_hold_pkg::CFG_WIDTH16_BIT];
            sel_wait_states <= '0;
        end else if (clk_en) begin
            region_select_n <= next_sel_n;
            sel_demux <= next_demux;
            sel_width16 <= next_width16;
            sel_wait_states <= next_wait;
        end
    end

    assign boot_region_select = region_select_n[cs_hold_pkg::BOOT_CS];

    // hold handshake
    assign takeover = takeover_protocol_enable && !takeover_req_n_in; // RULE_12

    always_comb begin
        next_state = state;
        next_grant_n = grant_n;
        next_req_n = 1'b1;
        case (state)
            cs_hold_pkg::HOLD_IDLE: begin
                next_grant_n = 1'b1;
                if (takeover) begin
                    next_state = cs_hold_pkg::HOLD_DRAIN;
                end
            end
            cs_hold_pkg::HOLD_DRAIN: begin
                if (!takeover) begin
                    next_state = cs_hold_pkg::HOLD_IDLE;
                end else if (!bus_cycle_active) begin
                    next_state = cs_hold_pkg::HOLD_GRANTED;
                    next_grant_n = 1'b0; // RULE_09
                end
            end
            cs_hold_pkg::HOLD_GRANTED: begin
                next_req_n = !bus_cycle_pending; // RULE_07
                if (!takeover) begin
                    next_state = cs_hold_pkg::HOLD_RESUME;
                    next_grant_n = 1'b1; // RULE_13
                    next_req_n = 1'b1;
                end
            end
            cs_hold_pkg::HOLD_RESUME: begin
                next_state = cs_hold_pkg::HOLD_IDLE;
            end
            default: begin
                next_state = cs_hold_pkg::HOLD_IDLE;
                next_grant_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= cs_hold_pkg::HOLD_IDLE;
            grant_n <= 1'b1;
            req_n <= 1'b1;
        end else if (clk_en) begin
            state <= next_state;
            grant_n <= next_grant_n;
            req_n <= next_req_n;
        end
    end

    // bus stays released from grant until the resume cycle ends
    assign bus_released = (state == cs_hold_pkg::HOLD_GRANTED) ||
                          (state == cs_hold_pkg::HOLD_RESUME); // RULE_13
    assign takeover_req_seen = takeover;

    // pin function muxing: protocol enable overrides port settings
    always_comb begin
        if (takeover_protocol_enable) begin
            bus_request_out = req_n; // RULE_08
            bus_request_oe_n = 1'b0; // RULE_08
            bus_grant_ack = grant_n; // RULE_10
            bus_grant_oe_n = 1'b0; // RULE_10
            takeover_oe_n = 1'b1; // RULE_12
        end else begin
            bus_request_out = port2_output_value[cs_hold_pkg::P2_REQ_OUT_BIT];
            bus_request_oe_n = port2_direction[cs_hold_pkg::P2_REQ_OUT_BIT];
            bus_grant_ack = port2_output_value[cs_hold_pkg::P2_GRANT_BIT];
            bus_grant_oe_n = port2_direction[cs_hold_pkg::P2_GRANT_BIT];
            takeover_oe_n = port2_direction[cs_hold_pkg::P2_TAKEOVER_BIT] ||
                            port2_function_select[cs_hold_pkg::P2_TAKEOVER_BIT];
        end
    end
endmodule

/* File: verification/cs_hold_props.sv */
// assertions on the chip-select and bus-hold ports
`timescale 1ns/1ps
module cs_hold_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic bus_cycle_active,
    input wire logic bus_cycle_pending,
    input wire logic takeover_protocol_enable,
    input wire logic takeover_req_n_in,
    input wire logic [5:0] port3_function_select,
    input wire logic [5:0] port3_output_value,
    input wire logic [5:0] region_hit,
    input wire logic [5:0] region_select_n,
    input wire logic boot_region_select,
    input wire logic bus_released,
    input wire logic bus_request_out,
    input wire logic bus_request_oe_n,
    input wire logic bus_grant_ack,
    input wire logic bus_grant_oe_n,
    input wire logic takeover_oe_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire en = takeover_protocol_enable;
    boot_reset_a: assert property ($rose(rst_n) |->
        !boot_region_select && region_select_n == 6'h3E) else $error("boot select idle");
    select_pin_a: assert property (clk_en |=> region_select_n ==
        (($past(port3_function_select) & ~($past(region_hit)
        & {6{$past(bus_cycle_active) && !$past(bus_released)}}))
        | (~$past(port3_function_select) & $past(port3_output_value)))) else $error("select");
    grant_released_a: assert property (en && !bus_grant_ack |-> bus_released)
        else $error("grant without release");
    grant_entry_a: assert property ($rose(bus_released) |->
        !$past(takeover_req_n_in) && !$past(bus_cycle_active)) else $error("early grant");
    grant_hold_a: assert property (en && !bus_grant_ack && !takeover_req_n_in && clk_en
        |=> !bus_grant_ack || !en) else $error("grant dropped");
    grant_drop_a: assert property (en && !bus_grant_ack && takeover_req_n_in && clk_en
        |=> bus_grant_ack) else $error("grant stuck");
    request_hold_a: assert property (en && bus_released && !bus_grant_ack
        && bus_cycle_pending && !takeover_req_n_in && clk_en |=> !bus_request_out)
        else $error("no request");
    pin_lock_a: assert property (en && $past(en) |->
        !bus_request_oe_n && !bus_grant_oe_n && takeover_oe_n) else $error("pin lock");
endmodule
bind chip_select_and_bus_hold cs_hold_props u_props (.*);

/* File: verification/ext_master.sv */
// external bus master asking for the bus
`timescale 1ns/1ps
module ext_master (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic [3:0] hold_len,
    input wire logic bus_grant_ack,
    output logic takeover_req_n
);
    logic [3:0] cnt;
    always @(negedge clk or negedge rst_n) begin
        if (!rst_n) begin
            takeover_req_n <= 1'b1;
            cnt <= 4'h0;
        end else if (!bus_grant_ack && cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end else if (!bus_grant_ack) begin
            takeover_req_n <= 1'b1;
        end else begin
            takeover_req_n <= ~go;
            cnt <= hold_len;
        end
    end
endmodule

/* File: verification/tb_top.sv */
// self-checking bench for the chip-select and bus-hold block
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, bus_cycle_pending = 1'b0, go = 1'b0;
    logic bus_cycle_active = 1'b0, cfg_write = 1'b0, takeover_protocol_enable = 1'b0;
    logic [19:0] bus_addr = 20'h00000;
    logic [2:0] cfg_index = 3'h0;
    logic [11:0] cfg_base = 12'h000, cfg_mask = 12'h000;
    logic [7:0] cfg_bus = 8'hC0, port2_function_select = 8'h00, port2_direction = 8'h00;
    logic [7:0] port2_output_value = 8'h00;
    logic [5:0] port3_function_select = 6'h3F, port3_output_value = 6'h00, region_select_n;
    logic [5:0] region_hit;
    logic [3:0] sel_wait_states, hold_len = 4'h3;
    logic boot_region_select, sel_demux, sel_width16, bus_released, bus_request_out;
    logic bus_request_oe_n, bus_grant_ack, bus_grant_oe_n, takeover_oe_n, takeover_req_seen;
    logic takeover_req_n_in;
    logic [11:0] mb [6], mm [6];
    logic [7:0] mc [6];
    int n_errors = 0, n_compared = 0;
    // pin levels with pull-ups when not driven
    wire bus_request_out_in = bus_request_oe_n ? 1'b1 : bus_request_out;
    wire bus_grant_ack_in = bus_grant_oe_n ? 1'b1 : bus_grant_ack;
    chip_select_and_bus_hold u_dut (.*);
    ext_master u_master (.clk, .rst_n, .go, .hold_len, .bus_grant_ack,
        .takeover_req_n(takeover_req_n_in));
    always #25 clk = ~clk;
    function automatic logic [5:0] exp_hit(logic [19:0] a);
        for (int i = 0; i < 6; i++)
            exp_hit[i] = ((a[19:8] ^ mb[i]) & mm[i]) == 12'h000;
    endfunction
    task automatic chk(logic [31:0] got, logic [31:0] exp, string msg);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic wait_grant(logic lvl);
        for (int k = 0; bus_grant_ack !== lvl; k++) begin
            if (k == 20) begin
                n_errors++;
                tally_and_finish();
            end
            @(negedge clk);
        end
    endtask
    task automatic do_reset();
        rst_n = 1'b0;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        mb = '{default: 12'hFFF};
        mm = '{default: 12'hFFF};
        mc = '{default: 8'hC0};
        mb[0] = 12'h000;
        mm[0] = 12'h000;
        chk({region_select_n, boot_region_select}, 7'h7C, "boot select");
        chk({sel_demux, sel_width16, sel_wait_states}, 6'h30, "boot bus type");
    endtask
    initial begin
        logic [5:0] h, ch;
        logic act;
        void'($urandom(64755));
        do_reset();
        $display("reset test done");
        repeat (60) begin
            @(negedge clk);
            {cfg_write, clk_en} = {1'b1, 1'($urandom_range(7) != 0)};
            {cfg_index, cfg_base, cfg_bus} = 23'($urandom);
            cfg_mask = $urandom_range(3) == 0 ? 12'hFFF : 12'($urandom);
            bus_addr = $urandom_range(1) ? {cfg_base, 8'($urandom)} : 20'($urandom);
            {act, port3_function_select, port3_output_value} = 13'($urandom);
            bus_cycle_active = 1'b0;
            if (clk_en && cfg_index < 3'h6) begin
                mb[cfg_index] = cfg_base;
                mm[cfg_index] = cfg_mask;
                mc[cfg_index] = cfg_bus;
            end
            @(negedge clk);
            {cfg_write, clk_en} = 2'b01;
            bus_cycle_active = act;
            h = exp_hit(bus_addr);
            chk(region_hit, h, "region hit");
            @(negedge clk);
            ch = port3_function_select & ~(h & {6{bus_cycle_active}});
            ch = ch | ~port3_function_select & port3_output_value;
            chk(region_select_n, ch, "select pin");
            // no active cycle on a hit: boot characteristics stand
            ch = 6'h30;
            for (int i = 5; i >= 0; i--)
                if (h[i] && bus_cycle_active) ch = {mc[i][7:6], mc[i][3:0]};
            chk({sel_demux, sel_width16, sel_wait_states}, ch, "bus type");
        end
        $display("decode test done");
        takeover_protocol_enable = 1'b1;
        repeat (6) begin
            {port2_function_select, port2_direction, port2_output_value} = 24'($urandom);
            hold_len = 4'($urandom_range(15, 3));
            bus_cycle_active = 1'b1;
            go <= 1'b1;
            repeat (3) @(negedge clk);
            chk(bus_grant_ack, 1'b1, "grant in cycle");
            bus_cycle_active = 1'b0;
            wait_grant(1'b0);
            go <= 1'b0;
            bus_cycle_pending = 1'b1;
            chk(bus_released, 1'b1, "released");
            chk({bus_request_oe_n, bus_grant_oe_n, takeover_oe_n}, 1, "oe");
            chk(takeover_req_seen, 1'b1, "request seen");
            @(negedge clk);
            chk(bus_request_out, 1'b0, "request");
            wait_grant(1'b1);
            bus_cycle_pending = 1'b0;
            @(negedge clk);
            chk({bus_released, takeover_req_n_in}, 2'b01, "resume");
        end
        // request withdrawn while the bus is still busy
        bus_cycle_active = 1'b1;
        go <= 1'b1;
        repeat (2) @(negedge clk);
        go <= 1'b0;
        repeat (2) @(negedge clk);
        bus_cycle_active = 1'b0;
        repeat (3) @(negedge clk);
        chk(bus_grant_ack, 1'b1, "aborted hold");
        takeover_protocol_enable = 1'b0;
        @(negedge clk);
        chk(bus_request_oe_n, port2_direction[3], "port mode");
        chk(bus_request_out, port2_output_value[3], "port value");
        chk(bus_grant_oe_n, port2_direction[6], "grant port mode");
        chk(bus_grant_ack, port2_output_value[6], "grant port value");
        $display("hold test done");
        do_reset();
        repeat (2) @(negedge clk);
        $display("second reset done");
        tally_and_finish();
    end
endmodule
